// ---- tdec_top.v ----
// Timer DMA request and event enable control with Avalon-MM registers
// Functional notes
// R1 - Capture channel requests DMA on valid data; cleared by reading its value.
// R2 - Capture mode ignores the DMA one-shot setting.
// R3 - Software/DMA writes buffer registers in order with update instants.
// R4 - Circular buffers are meant only for dual-ramp and dual-slope-both modes.
// R5 - Ramp modes: circular compare channel requests at start of ramp B.
// R6 - Ramp modes: overflow request at ramp A start only after ramp-B ack.
// R7 - Ramp modes: DMA refreshes ramp A via match, ramp B via overflow.
// R8 - Dual-slope: circular compare channel requests at start of down-count.
// R9 - Dual-slope: overflow request at up-count start only after down-count ack.
// R10 - Dual-slope: DMA updates up via match, down via overflow.
// R11 - Channel event output enable bits 27:24 gate per-channel match/capture events.
// R12 - Channel event input enable bits 19:16 gate incoming channel events.
// R13 - Timer event input enable bits 15:14 gate timer input events.
// R14 - Invert bits 13:12 invert timer event inputs before use.
// R15 - All event control fields reset to zero and are read/write.
// R16 - Event control layout: bits 10,9,8, 7:6, 5:3, 2:0.
`timescale 1ns/1ps
`include "tdec_consts.vh"
module tdec_top #(
  parameter NCH = 4
) (
  input  wire            clk_i,
  input  wire            rstn_i,
  // Avalon-MM slave
  input  wire [5:0]      address_i,
  input  wire            read_i,
  input  wire            write_i,
  input  wire [31:0]     writedata_i,
  input  wire [3:0]      byteenable_i,
  output reg  [31:0]     readdata_o,
  output wire            waitrequest_o,
  // Counter core status
  input  wire            start_a_i,
  input  wire            start_b_i,
  input  wire            ovf_i,
  input  wire            retrig_i,
  input  wire            count_i,
  input  wire [NCH-1:0]  match_i,
  input  wire [NCH-1:0]  capt_valid_i,
  input  wire [NCH-1:0]  cc_read_i,
  // DMA controller
  input  wire [NCH-1:0]  chan_ack_i,
  input  wire            ovf_ack_i,
  output wire [NCH-1:0]  chan_req_o,
  output reg             ovf_req_o,
  // Event system
  input  wire [1:0]      timer_ev_i,
  input  wire [NCH-1:0]  chan_ev_i,
  output reg  [1:0]      timer_ev_o,
  output reg  [NCH-1:0]  chan_ev_o,
  output reg  [NCH-1:0]  mc_ev_o,
  output reg             ovf_ev_o,
  output reg             retrig_ev_o,
  output reg             count_ev_o,
  output reg  [1:0]      counter_event_select_o,
  output reg  [2:0]      event_action_zero_o,
  output reg  [2:0]      event_action_one_o,
  output wire            irq_o
);
  // ****************************************
  // Reset release
  // ****************************************
  reg rst_s1_q;
  reg rst_n_q;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  reg [1:0]     tev_s1_q;
  reg [1:0]     tev_s2_q;
  reg [NCH-1:0] cev_s1_q;
  reg [NCH-1:0] cev_s2_q;
  // Event lines come from another clock tree, so two stages each
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tev_s1_q <= 2'h0;
      tev_s2_q <= 2'h0;
      cev_s1_q <= {NCH{1'b0}};
      cev_s2_q <= {NCH{1'b0}};
    end else begin
      tev_s1_q <= timer_ev_i;
      tev_s2_q <= tev_s1_q;
      cev_s1_q <= chan_ev_i;
      cev_s2_q <= cev_s1_q;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  reg [31:0] ev_ctrl_q;
  reg [31:0] dma_ctrl_q;
  reg [5:0]  int_stat_q;
  reg [5:0]  int_en_q;
  reg        armed_q;
  reg [NCH-1:0] cc_rd_q;
  wire [1:0]     wave    = dma_ctrl_q[`TDEC_WAVE_LSB+1:`TDEC_WAVE_LSB];
  wire           oneshot = dma_ctrl_q[`TDEC_ONESHOT_BIT];
  wire [NCH-1:0] circ    = dma_ctrl_q[`TDEC_CIRC_LSB+NCH-1:`TDEC_CIRC_LSB];
  wire [NCH-1:0] capt    = dma_ctrl_q[`TDEC_CAPT_LSB+NCH-1:`TDEC_CAPT_LSB];
  wire ramp_mode  = (wave == `TDEC_WAVE_DUAL_RAMP_WAVEFORM) || (wave == `TDEC_WAVE_DUAL_RAMP_ALT_WAVEFORM);
  wire slope_mode = (wave == `TDEC_WAVE_DUAL_SLOPE_BOTH_WAVEFORM);
  wire circ_mode  = ramp_mode || slope_mode;
  wire any_circ   = |(circ & ~capt);
  wire wr_acc     = write_i && !read_i;

  // Byte-enable merge used for the event and DMA control words
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    input [31:0] mask;
    integer k;
    begin
      be_merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          be_merge[k*8 +: 8] = new_v[k*8 +: 8];
      be_merge = be_merge & mask;
    end
  endfunction

  // Zero-wait slave: every access completes in its first cycle
  assign waitrequest_o = 1'b0;

  // Control words, written by software
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ev_ctrl_q  <= `TDEC_RESET_WORD;                    // [R15]
      dma_ctrl_q <= `TDEC_RESET_WORD;
      int_en_q   <= 6'h00;
    end else if (wr_acc) begin
      case (address_i)
        `TDEC_OFF_EVCTRL:
          ev_ctrl_q <= be_merge(ev_ctrl_q, writedata_i, byteenable_i, `TDEC_EVCTRL_MASK); // [R15]
        `TDEC_OFF_DMACTRL:
          dma_ctrl_q <= be_merge(dma_ctrl_q, writedata_i, byteenable_i, `TDEC_DMACTRL_MASK);
        `TDEC_OFF_INTEN:
          if (byteenable_i[0])
            int_en_q <= writedata_i[5:0];
        default: ;
      endcase
    end
  end

  // Reading the value word counts as reading the channel value
  always @* begin
    cc_rd_q = cc_read_i;
    if (read_i && (address_i == `TDEC_OFF_CCDATA) && byteenable_i[0])
      cc_rd_q = cc_read_i | writedata_i[NCH-1:0];
  end

  // Read data decoded combinationally from the address, not registered
  always @* begin
    readdata_o = 32'h00000000;
    case (address_i)
      `TDEC_OFF_EVCTRL:  readdata_o = ev_ctrl_q;
      `TDEC_OFF_DMACTRL: readdata_o = dma_ctrl_q;
      `TDEC_OFF_DMASTAT: readdata_o = {26'h0, ovf_req_o, armed_q, chan_req_o};
      `TDEC_OFF_INTSTAT: readdata_o = {26'h0, int_stat_q};
      `TDEC_OFF_INTEN:   readdata_o = {26'h0, int_en_q};
      default:           readdata_o = 32'h00000000;
    endcase
  end

  // ****************************************
  // Channel DMA requests
  // ****************************************
  wire start_circ_b = ramp_mode ? start_b_i : start_a_i;  // Ramp B start in ramp modes, start_a otherwise
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      tdec_chan_req u_req (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_q),
        .capture_i    (capt[g]),
        .circ_i       (circ[g]),
        .circ_mode_i  (circ_mode),
        .oneshot_i    (oneshot),
        .match_i      (match_i[g]),
        .capt_valid_i (capt_valid_i[g]),
        .cc_read_i    (cc_rd_q[g]),
        .start_b_i    (slope_mode ? start_b_i : start_circ_b), // [R5] [R8]
        .ack_i        (chan_ack_i[g]),
        .armed_i      (armed_q),
        .req_o        (chan_req_o[g])
      );
    end
  endgenerate

  // ****************************************
  // Overflow DMA request
  // ****************************************
  // In dual-slope, start_a marks up-count start and start_b down-count start
  reg ack_seen_q;
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_seen_q <= 1'b0;
      ovf_req_o  <= 1'b0;
      armed_q    <= 1'b1;
    end else begin
      // Ack seen during ramp B / down phase; a new B phase restarts the window
      if (start_b_i)
        ack_seen_q <= 1'b0;
      else if (|chan_ack_i || ovf_ack_i)
        ack_seen_q <= 1'b1;                              // [R6] [R9]
      if (circ_mode && any_circ) begin
        if (start_a_i && ack_seen_q)
          ovf_req_o <= 1'b1;                             // [R6] [R9]
        else if (ovf_ack_i)
          ovf_req_o <= 1'b0;
      end else begin
        if (ovf_i && (!oneshot || armed_q))
          ovf_req_o <= 1'b1;
        else if (ovf_ack_i)
          ovf_req_o <= 1'b0;
      end
      // One-shot: first overflow or non-capture channel ack disarms until software rewrites control
      if (wr_acc && address_i == `TDEC_OFF_DMACTRL)
        armed_q <= 1'b1;
      else if (oneshot && (ovf_ack_i || |(chan_ack_i & ~capt)))
        armed_q <= 1'b0;
    end
  end

  // ****************************************
  // Event inputs and outputs
  // ****************************************
  wire [1:0] tev_inv = tev_s2_q ^ ev_ctrl_q[`TDEC_TCINV_LSB+1:`TDEC_TCINV_LSB];  // [R14]
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      timer_ev_o             <= 2'h0;
      chan_ev_o              <= {NCH{1'b0}};
      mc_ev_o                <= {NCH{1'b0}};
      ovf_ev_o               <= 1'b0;
      retrig_ev_o            <= 1'b0;
      count_ev_o             <= 1'b0;
      counter_event_select_o <= 2'h0;
      event_action_zero_o    <= 3'h0;
      event_action_one_o     <= 3'h0;
    end else begin
      timer_ev_o  <= tev_inv & ev_ctrl_q[`TDEC_TCEI_LSB+1:`TDEC_TCEI_LSB];        // [R13]
      chan_ev_o   <= cev_s2_q & ev_ctrl_q[`TDEC_MCEI_LSB+NCH-1:`TDEC_MCEI_LSB];   // [R12]
      mc_ev_o     <= (match_i | capt_valid_i) & ev_ctrl_q[`TDEC_MCEO_LSB+NCH-1:`TDEC_MCEO_LSB]; // [R11]
      ovf_ev_o    <= ovf_i & ev_ctrl_q[`TDEC_OVERFLOW_EVENT_OUT_ENABLE_BIT];                       // [R16]
      retrig_ev_o <= retrig_i & ev_ctrl_q[`TDEC_RETRIGGER_EVENT_OUT_ENABLE_BIT];                    // [R16]
      count_ev_o  <= count_i & ev_ctrl_q[`TDEC_COUNTER_EVENT_OUT_ENABLE_BIT];                     // [R16]
      counter_event_select_o <= ev_ctrl_q[7:6];                                // [R16]
      event_action_one_o     <= ev_ctrl_q[5:3];                                // [R16]
      event_action_zero_o    <= ev_ctrl_q[2:0];                                // [R16]
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Set wins over a clear landing in the same cycle
  wire [5:0] int_set = {ovf_req_o & ~ovf_ack_i & 1'b0, ovf_i, chan_req_o};
  wire       clr_wr  = wr_acc && (address_i == `TDEC_OFF_INTCLR) && byteenable_i[0];
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q)
      int_stat_q <= 6'h00;
    else
      int_stat_q <= (int_stat_q & ~(clr_wr ? writedata_i[5:0] : 6'h00)) | int_set;
  end
  assign irq_o = |(int_stat_q & int_en_q);
endmodule // tdec_top

// ---- tdec_consts.vh ----
// Constants for the timer DMA and event control block
`ifndef TDEC_CONSTS_VH
`define TDEC_CONSTS_VH
// Register word offsets (byte addresses)
`define TDEC_OFF_EVCTRL   6'h00
`define TDEC_OFF_DMACTRL  6'h04
`define TDEC_OFF_DMASTAT  6'h08
`define TDEC_OFF_INTSTAT  6'h0C
`define TDEC_OFF_INTCLR   6'h10
`define TDEC_OFF_INTEN    6'h14
`define TDEC_OFF_CCDATA   6'h18
// Event control fields
`define TDEC_MCEO_LSB     24
`define TDEC_MCEI_LSB     16
`define TDEC_TCEI_LSB     14
`define TDEC_TCINV_LSB    12
`define TDEC_COUNTER_EVENT_OUT_ENABLE_BIT    10
`define TDEC_RETRIGGER_EVENT_OUT_ENABLE_BIT    9
`define TDEC_OVERFLOW_EVENT_OUT_ENABLE_BIT    8
`define TDEC_EVCTRL_MASK  32'h0F0FF7FF
// DMA control fields
`define TDEC_WAVE_LSB     0
`define TDEC_ONESHOT_BIT  2
`define TDEC_CIRC_LSB     4
`define TDEC_CAPT_LSB     8
`define TDEC_DMACTRL_MASK 32'h00000FF7
// Waveform mode codes
`define TDEC_WAVE_NORMAL  2'h0
`define TDEC_WAVE_DUAL_RAMP_WAVEFORM   2'h1
`define TDEC_WAVE_DUAL_RAMP_ALT_WAVEFORM  2'h2
`define TDEC_WAVE_DUAL_SLOPE_BOTH_WAVEFORM  2'h3
// Interrupt status bits
`define TDEC_IRQ_OVF      4
`define TDEC_IRQ_W        5
`define TDEC_RESET_WORD   32'h00000000
`endif

// ---- tdec_chan_req.v ----
// One compare/capture channel DMA request generator
`timescale 1ns/1ps
module tdec_chan_req (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire capture_i,
  input  wire circ_i,
  input  wire circ_mode_i,
  input  wire oneshot_i,
  input  wire match_i,
  input  wire capt_valid_i,
  input  wire cc_read_i,
  input  wire start_b_i,
  input  wire ack_i,
  input  wire armed_i,
  output reg  req_o
);
  // ****************************************
  // Request flag
  // ****************************************
  // Capture: set on valid data, clear on read, one-shot ignored
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= 1'b0;
    end else if (capture_i) begin
      if (capt_valid_i)                                  // [R1] [R2]
        req_o <= 1'b1;
      else if (cc_read_i)
        req_o <= 1'b0;                                   // [R1]
    end else begin
      if ((circ_i && circ_mode_i) ? start_b_i            // [R5] [R8]
          : (match_i && (!oneshot_i || armed_i)))
        req_o <= 1'b1;
      else if (ack_i)
        req_o <= 1'b0;
    end
  end
endmodule // tdec_chan_req

// ---- tdec_props.sv ----
// Checker for DMA request timing and event enables of the timer block
`timescale 1ns/1ps
`include "tdec_consts.vh"
module tdec_props #(
  parameter NCH = 4
) (
  input wire           clk_i,
  input wire           rstn_i,
  input wire [5:0]     address_i,
  input wire           read_i,
  input wire           write_i,
  input wire [31:0]    writedata_i,
  input wire [3:0]     byteenable_i,
  input wire [31:0]    readdata_o,
  input wire           start_a_i,
  input wire           start_b_i,
  input wire           ovf_i,
  input wire           retrig_i,
  input wire           count_i,
  input wire [NCH-1:0] match_i,
  input wire [NCH-1:0] capt_valid_i,
  input wire [NCH-1:0] cc_read_i,
  input wire [NCH-1:0] chan_ack_i,
  input wire           ovf_ack_i,
  input wire [NCH-1:0] chan_req_o,
  input wire           ovf_req_o,
  input wire [NCH-1:0] mc_ev_o,
  input wire           ovf_ev_o,
  input wire           retrig_ev_o,
  input wire           count_ev_o,
  input wire [1:0]     counter_event_select_o,
  input wire [2:0]     event_action_zero_o,
  input wire [2:0]     event_action_one_o
);
  // ****
  // Shadow of written control words
  // ****
  logic [31:0] ev_q;
  logic [31:0] dma_q;
  logic        ack_q;
  wire  [2:0]  gen_c = {count_i, retrig_i, ovf_i};
  wire         circ_on = |dma_q[7:4] && |dma_q[1:0];
  // Any ack opens the overflow window; start of ramp B closes it
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev_q  <= 32'h0;
      dma_q <= 32'h0;
      ack_q <= 1'b0;
    end else begin
      ack_q <= !start_b_i && (ack_q || |chan_ack_i || ovf_ack_i);
      for (int b = 0; b < 4; b++) begin
        if (write_i && byteenable_i[b] && address_i == `TDEC_OFF_EVCTRL) ev_q[b*8+:8] <= writedata_i[b*8+:8];
        if (write_i && byteenable_i[b] && address_i == `TDEC_OFF_DMACTRL) dma_q[b*8+:8] <= writedata_i[b*8+:8];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_read_back:
    assert property (read_i && address_i == `TDEC_OFF_EVCTRL |-> readdata_o == (ev_q & `TDEC_EVCTRL_MASK))
      else $error("event control read mismatch");
  a_field_copy:
    assert property ({counter_event_select_o, event_action_one_o, event_action_zero_o} == $past(ev_q[7:0]))
      else $error("event field copies wrong");
  a_gen_ev:
    assert property ({count_ev_o, retrig_ev_o, ovf_ev_o} == ($past(gen_c) & $past(ev_q[10:8])))
      else $error("counter event output wrong");
  a_mc_ev:
    assert property (mc_ev_o == (($past(match_i) | $past(capt_valid_i)) & $past(ev_q[27:24])))
      else $error("channel event output wrong");
  a_req_hold:
    assert property ($fell(chan_req_o[0]) |-> $past(chan_ack_i[0]) || $past(cc_read_i[0]) || $past(read_i) || $past(write_i))
      else $error("channel request dropped without cause");
  a_circ_req_b:
    assert property ($rose(chan_req_o[0]) && $past(circ_on) && $past(dma_q[4]) && !$past(dma_q[8]) |-> $past(start_b_i))
      else $error("circular request not at second phase start");
  a_ovf_at_a:
    assert property ($rose(ovf_req_o) && $past(circ_on) |-> $past(start_a_i))
      else $error("overflow request not at first phase start");
  a_ovf_ack:
    assert property ($rose(ovf_req_o) && $past(circ_on) |-> $past(ack_q))
      else $error("overflow request without earlier ack");
  c_ovf_circ: cover property ($rose(ovf_req_o) && $past(circ_on));
  c_capt_clear: cover property ($fell(chan_req_o[1]));
  c_mc_ev: cover property (|mc_ev_o);
endmodule // tdec_props
bind tdec_top tdec_props #(.NCH(NCH)) u_tdec_props (.*);

// ---- tdec_dma_model.sv ----
// DMA controller stand-in that acknowledges each request after a set wait
`timescale 1ns/1ps
module tdec_dma_model #(
  parameter NCH = 4
) (
  input  wire          clk_i,
  input  wire          rstn_i,
  input  wire          en_i,
  input  wire [3:0]    dly_i,
  input  wire [NCH:0]  req_i,
  output logic [NCH:0] ack_o
);
  logic [3:0] cnt_q [NCH+1];
  // One-cycle ack per request; a stalled model never answers
  always @(posedge clk_i or negedge rstn_i) begin
    for (int i = 0; i <= NCH; i++) begin
      if (!rstn_i || ack_o[i] || !req_i[i] || !en_i) begin
        ack_o[i] <= 1'b0;
        cnt_q[i] <= 4'h0;
      end else if (cnt_q[i] == dly_i) begin
        ack_o[i] <= 1'b1; // Refresh per phase via match and overflow triggers
      end else begin
        cnt_q[i] <= cnt_q[i] + 4'h1;
      end
    end
  end
endmodule // tdec_dma_model

// ---- tdec_top_tb_top.sv ----
// Self-checking testbench for the timer DMA and event control block
`timescale 1ns/1ps
`include "tdec_consts.vh"
module tdec_top_tb_top;
  logic        clk_i, rstn_i, read_i, write_i, en;
  logic [5:0]  address_i;
  logic [31:0] writedata_i, rd;
  logic [3:0]  byteenable_i, chan_ev_i, dly;
  logic [1:0]  timer_ev_i;
  logic [16:0] pv;
  wire  [3:0]  match_i, capt_valid_i, cc_read_i, chan_ack_i, chan_req_o, chan_ev_o, mc_ev_o;
  wire         start_a_i, start_b_i, ovf_i, retrig_i, count_i, ovf_ack_i, ovf_req_o, waitrequest_o;
  wire         ovf_ev_o, retrig_ev_o, count_ev_o, irq_o;
  wire  [31:0] readdata_o;
  wire  [1:0]  timer_ev_o, counter_event_select_o;
  wire  [2:0]  event_action_zero_o, event_action_one_o;
  int          errors, samples_checked;
  // Counter pulses packed for short scenario calls
  assign {match_i, capt_valid_i, cc_read_i, start_a_i, start_b_i, count_i, retrig_i, ovf_i} = pv;
  tdec_top u_tdec_top (.*);
  tdec_dma_model u_tdec_dma_model (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en), .dly_i(dly),
    .req_i({ovf_req_o, chan_req_o}), .ack_o({ovf_ack_i, chan_ack_i}));
  // ****
  // Helpers
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon-MM cycle; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    write_i <= wr;
    read_i <= !wr;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask
  task automatic pulse(input logic [16:0] v);
    pv <= v;
    tick(1);
    pv <= 17'h0;
    // Look at registered outputs once they have settled, not in the launching step
    @(negedge clk_i);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Free-running 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    tick(5000);
    errors++;
    tally_and_finish();
  end
  initial begin
    {rstn_i, read_i, write_i, en, address_i, writedata_i, byteenable_i, chan_ev_i, dly, timer_ev_i, pv} = '0;
    tick(6);
    rstn_i <= 1'b1;
    tick(3);
    // Reset values, and an unmapped write that must not stick
    bus(1'b1, 6'h3C, 32'hFFFFFFFF, 4'hF);
    for (int a = 0; a < 64; a += 4) begin
      bus(1'b0, 6'(a), 32'h0, 4'hF);
      chk(rd, (a == 8) ? 32'h10 : 32'h0);
    end
    // Field layout, output enables and input gating
    bus(1'b1, `TDEC_OFF_EVCTRL, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, `TDEC_OFF_EVCTRL, 32'h0, 4'hF);
    chk(rd, `TDEC_EVCTRL_MASK);
    bus(1'b1, `TDEC_OFF_EVCTRL, 32'h0A05A2D3, 4'hF);
    tick(3);
    chk({counter_event_select_o, event_action_one_o, event_action_zero_o}, 8'hD3);
    pulse({4'hF, 8'h0, 5'h7});
    chk(mc_ev_o, 4'hA);
    chk({count_ev_o, retrig_ev_o, ovf_ev_o}, 3'h2);
    chan_ev_i <= 4'hF;
    timer_ev_i <= 2'h1;
    tick(6);
    chk(chan_ev_o, 4'h5);
    chk(timer_ev_o, 2'h2);
    timer_ev_i <= 2'h2;
    tick(6);
    chk(timer_ev_o, 2'h0);
    bus(1'b1, `TDEC_OFF_EVCTRL, 32'h0, 4'h1);
    bus(1'b0, `TDEC_OFF_EVCTRL, 32'h0, 4'hF);
    chk(rd, 32'h0A05A200);
    bus(1'b1, `TDEC_OFF_EVCTRL, 32'h0, 4'hF);
    // Let the model drain the normal-mode requests, then clear status
    en <= 1'b1;
    tick(12);
    en <= 1'b0;
    bus(1'b1, `TDEC_OFF_INTCLR, 32'h1F, 4'hF);
    // Capture channel 1 with one-shot set: request, interrupt, clearing reads
    bus(1'b1, `TDEC_OFF_DMACTRL, 32'h204, 4'hF);
    bus(1'b1, `TDEC_OFF_INTEN, 32'h2, 4'hF);
    pulse({4'h0, 4'h2, 9'h0});
    chk(chan_req_o, 4'h2);
    bus(1'b0, `TDEC_OFF_INTSTAT, 32'h0, 4'hF);
    chk(rd, 32'h2);
    chk(irq_o, 1'b1);
    bus(1'b1, `TDEC_OFF_INTEN, 32'h0, 4'hF);
    tick(1);
    chk(irq_o, 1'b0);
    pulse({8'h0, 4'h2, 5'h0});
    chk(chan_req_o, 4'h0);
    bus(1'b1, `TDEC_OFF_INTCLR, 32'h2, 4'hF);
    bus(1'b0, `TDEC_OFF_INTSTAT, 32'h0, 4'hF);
    chk(rd, 32'h0);
    // Disarm one-shot via a compare ack on channel 0, so the capture check bites
    pulse({4'h1, 13'h0});
    en <= 1'b1;
    tick(4);
    en <= 1'b0;
    bus(1'b0, `TDEC_OFF_DMASTAT, 32'h0, 4'hF);
    chk(rd, 32'h0);
    pulse({4'h0, 4'h2, 9'h0});
    chk(chan_req_o, 4'h2);
    bus(1'b0, `TDEC_OFF_CCDATA, 32'h2, 4'hF);
    tick(1);
    chk(chan_req_o, 4'h0);
    // Circular channel 0, only in the dual-ramp and dual-slope modes
    for (int w = 1; w < 4; w++) begin
      dly <= 4'(w * 3);
      bus(1'b1, `TDEC_OFF_DMACTRL, 32'h10 | w, 4'hF);
      pulse({4'h1, 13'h0});
      chk(chan_req_o[0], 1'b0);
      pulse({12'h0, 5'h08});
      chk(chan_req_o[0], 1'b1);
      pulse({12'h0, 5'h10});
      chk(ovf_req_o, 1'b0);
      en <= 1'b1;
      tick(15);
      chk(chan_req_o[0], 1'b0);
      pulse({12'h0, 5'h10});
      chk(ovf_req_o, 1'b1);
      tick(15);
      en <= 1'b0;
      chk(ovf_req_o, 1'b0);
    end
    tally_and_finish();
  end
endmodule // tdec_top_tb_top
